// ---- pwi_pkg.sv ----
/*
  shared constants for the wiper two-wire slave and its bus master.
  assumes one 20 MHz clock on both ends and a wired-and bus in pwi_if.
*/
// Function
// - transmitter releases line; receiver acks ninth clock
// - slave acks start plus matching identification; a read one only after an address byte set the pointer
// - slave acks valid address byte after identification
// - slave acks the single written data byte; a further one gets nack
// - master acks each data byte it reads except the last
// - top seven identification bits must match code
// - identification lsb: one reads, zero writes
// - write is start, id, address, data, stop
// - completed write returns slave to standby
// - write data shifts in, wiper untouched meanwhile
// - address zero copies data at last-bit fall
// - nonzero address or foreign identification gets nack
// - read header: id write, address, restart, id read
// - slave keeps sending while master acks
// - master ends read with stop after last byte
// - bytes travel most significant bit first
// - start/stop only while clock high; else data
// - seven-bit wiper presets to 40h
package pwi_pkg;

  // ----------------------------------------------------------------
  // identity and register values
  // ----------------------------------------------------------------
  // arbitrary slave code, not tied to any real part
  localparam logic [6:0] DEV_ID_DFLT = 7'h2A;
  localparam logic [6:0] WIPER_RST = 7'h40;
  localparam logic [7:0] WIPER_ADDR = 8'h00;
  localparam logic RW_READ = 1'b1;
  localparam logic RW_WRITE = 1'b0;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCL_PERIOD_NS = 10000;
  // quarter of a serial clock period in system clocks, rounded down
  localparam int QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

endpackage

// ---- pwi_if.sv ----
/*
  open-drain two-wire bus joining the master end and the slave end.
  assumes each party drives only its own output enables; a low is
  pulled while enable is high, otherwise the pull-up wins.
*/
`timescale 1ns/100ps
interface pwi_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;

  // ----------------------------------------------------------------
  // wired-and resolution
  // ----------------------------------------------------------------
  assign scl = m_scl_oe ? m_scl_o : 1'b1;
  assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (s_sda_oe ? s_sda_o : 1'b1);

  modport mst (input scl, input sda, output m_scl_o, output m_scl_oe,
               output m_sda_o, output m_sda_oe);
  modport dev (input scl, input sda, output s_sda_o, output s_sda_oe);
endinterface

// ---- pwi_dev.sv ----
/*
  slave end: decodes start/stop, identification, address and data,
  holds the 7-bit wiper and returns it on reads.
  assumes the master keeps each serial clock phase longer than four
  system clocks, since both lines are sampled through synchronisers.
*/
`timescale 1ns/100ps
module pwi_dev #(
  parameter logic [6:0] DEV_ID = pwi_pkg::DEV_ID_DFLT
) (
  input wire logic clk,
  input wire logic rst,
  pwi_if.dev bus,
  output logic [6:0] wiper
);
  import pwi_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK} pwi_dst_t;
  typedef enum logic [2:0] {K_ID, K_ADDR, K_DATA, K_RD, K_DONE} pwi_kind_t;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // stage 0 feeds stage 1 only; stage 2 is the previous sample
  logic [2:0] scl_sh_q;
  logic [2:0] sda_sh_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_sh_q <= 3'h7;
      sda_sh_q <= 3'h7;
    end else begin
      scl_sh_q <= {scl_sh_q[1:0], bus.scl};
      sda_sh_q <= {sda_sh_q[1:0], bus.sda};
    end
  end

  wire scl_s = scl_sh_q[1];
  wire scl_p = scl_sh_q[2];
  wire sda_s = sda_sh_q[1];
  wire sda_p = sda_sh_q[2];

  // ----------------------------------------------------------------
  // line events
  // ----------------------------------------------------------------
  wire scl_rise = scl_s & ~scl_p;
  wire scl_fall = ~scl_s & scl_p;
  wire start_det = scl_s & scl_p & sda_p & ~sda_s;
  wire stop_det = scl_s & scl_p & ~sda_p & sda_s;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pwi_dst_t state_q;
  pwi_dst_t state_d;
  pwi_kind_t kind_q;
  pwi_kind_t kind_d;
  logic [3:0] bit_q;
  logic [3:0] bit_d;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic [7:0] tx_d;
  logic sda_oe_q;
  logic sda_oe_d;
  logic addr_ok_q;
  logic addr_ok_d;
  logic mack_q;
  logic mack_d;
  logic [6:0] wiper_q;

  // ----------------------------------------------------------------
  // byte decode
  // ----------------------------------------------------------------
  wire byte_done = scl_fall & (bit_q == BYTE_BITS);
  wire id_match = (sh_q[7:1] == DEV_ID);
  wire id_rd = (sh_q[0] == RW_READ);
  wire addr_zero = (sh_q == WIPER_ADDR);
  // a read is only honoured after an address byte set the pointer
  wire ack_id = id_match & (~id_rd | addr_ok_q);
  wire byte_ack = (kind_q == K_ID) ? ack_id :
                  (kind_q == K_ADDR) ? addr_zero :
                  (kind_q == K_DATA) ? addr_ok_q :
                  1'b0;
  wire pwi_kind_t kind_nx = (kind_q == K_ID) ? (id_rd ? K_RD : K_ADDR) :
                            (kind_q == K_ADDR) ? K_DATA : K_DONE;
  wire [7:0] tx_word = {1'b0, wiper_q};
  wire commit = (state_q == ST_RX) & byte_done & (kind_q == K_DATA) & addr_ok_q;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    kind_d = kind_q;
    bit_d = bit_q;
    tx_d = tx_q;
    sda_oe_d = sda_oe_q;
    addr_ok_d = addr_ok_q;
    mack_d = mack_q;
    if (stop_det) begin
      state_d = ST_IDLE;
      sda_oe_d = 1'b0;
      addr_ok_d = 1'b0;
    end else if (start_det) begin
      // a repeated start keeps the address pointer
      state_d = ST_RX;
      kind_d = K_ID;
      bit_d = 4'h0;
      sda_oe_d = 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          sda_oe_d = 1'b0;
        end
        ST_RX: begin
          if (scl_rise) begin
            bit_d = bit_q + 4'h1;
          end else if (byte_done) begin
            kind_d = kind_nx;
            if (kind_q == K_ID && !id_rd) begin
              addr_ok_d = 1'b0;
            end
            if (kind_q == K_ADDR && addr_zero) begin
              addr_ok_d = 1'b1;
            end
            if (byte_ack) begin
              state_d = ST_ACK;
              sda_oe_d = 1'b1;
            end else begin
              state_d = ST_IDLE;
              sda_oe_d = 1'b0;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_d = 4'h0;
            if (kind_q == K_RD) begin
              state_d = ST_TX;
              tx_d = tx_word;
              sda_oe_d = ~tx_word[7];
            end else begin
              state_d = ST_RX;
              sda_oe_d = 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            bit_d = bit_q + 4'h1;
          end else if (scl_fall) begin
            if (bit_q == BYTE_BITS) begin
              state_d = ST_TXACK;
              sda_oe_d = 1'b0;
            end else begin
              tx_d = {tx_q[6:0], 1'b0};
              sda_oe_d = ~tx_q[6];
            end
          end
        end
        ST_TXACK: begin
          if (scl_rise) begin
            mack_d = ~sda_s;
          end else if (scl_fall) begin
            bit_d = 4'h0;
            if (mack_q) begin
              state_d = ST_TX;
              tx_d = tx_word;
              sda_oe_d = ~tx_word[7];
            end else begin
              state_d = ST_IDLE;
              sda_oe_d = 1'b0;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      kind_q <= K_ID;
      bit_q <= 4'h0;
      tx_q <= 8'h00;
      sda_oe_q <= 1'b0;
      addr_ok_q <= 1'b0;
      mack_q <= 1'b0;
    end else begin
      state_q <= state_d;
      kind_q <= kind_d;
      bit_q <= bit_d;
      tx_q <= tx_d;
      sda_oe_q <= sda_oe_d;
      addr_ok_q <= addr_ok_d;
      mack_q <= mack_d;
    end
  end

  // incoming bits collect here; the wiper only moves on commit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sh_q <= 8'h00;
    end else if (state_q == ST_RX && scl_rise) begin
      sh_q <= {sh_q[6:0], sda_s};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wiper_q <= WIPER_RST;
    end else if (commit) begin
      wiper_q <= sh_q[6:0];
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // open drain: only ever pulls low
  assign bus.s_sda_o = 1'b0;
  assign bus.s_sda_oe = sda_oe_q;
  assign wiper = wiper_q;

endmodule // pwi_dev

// ---- pwi_mst.sv ----
/*
  master end: runs one write or one read transfer per command,
  making the serial clock from the system clock by a divider.
  assumes QTR of at least 4 so the synchronised data is settled.
*/
`timescale 1ns/100ps
module pwi_mst #(
  parameter int QTR = pwi_pkg::QTR_CYC,
  parameter logic [6:0] DEV_ID = pwi_pkg::DEV_ID_DFLT
) (
  input wire logic clk,
  input wire logic rst,
  pwi_if.mst bus,
  input wire logic cmd_go,
  input wire logic cmd_rd,
  input wire logic [7:0] cmd_wdata,
  input wire logic [3:0] cmd_nrd,
  output logic busy,
  output logic done,
  output logic nack,
  output logic [7:0] rd_data,
  output logic rd_valid
);
  import pwi_pkg::*;

  typedef enum logic [2:0] {M_IDLE, M_NEXT, M_START, M_BIT, M_STOP} pwi_mst_t;
  typedef enum logic [2:0] {IT_S, IT_IDW, IT_ADDR, IT_DATA, IT_IDR, IT_RB, IT_P} pwi_it_t;

  localparam logic [15:0] QTR_M1 = 16'(QTR - 1);

  // ----------------------------------------------------------------
  // transfer sequence
  // ----------------------------------------------------------------
  function automatic pwi_it_t item(input logic [3:0] step, input logic rd,
                                   input logic [3:0] left);
    if (step == 4'h0) item = IT_S;
    else if (step == 4'h1) item = IT_IDW;
    else if (step == 4'h2) item = IT_ADDR;
    else if (step == 4'h3) item = rd ? IT_S : IT_DATA;
    else if (step == 4'h4) item = rd ? IT_IDR : IT_P;
    else item = (left != 4'h0) ? IT_RB : IT_P;
  endfunction

  logic [1:0] sda_sh_q;
  pwi_mst_t st_q;
  logic [15:0] div_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [3:0] step_q;
  logic [3:0] left_q;
  logic rd_q;
  logic rxm_q;
  logic [7:0] wd_q;
  logic [7:0] sh_q;
  logic scl_oe_q;
  logic sda_oe_q;
  logic busy_q;
  logic done_q;
  logic nack_q;
  logic [7:0] rd_data_q;
  logic rd_valid_q;

  wire sda_s = sda_sh_q[1];
  wire tick = (div_q == QTR_M1);
  wire pwi_it_t cur = item(step_q, rd_q, left_q);
  wire [7:0] tx_byte = (cur == IT_IDW) ? {DEV_ID, RW_WRITE} :
                       (cur == IT_IDR) ? {DEV_ID, RW_READ} :
                       (cur == IT_ADDR) ? WIPER_ADDR : wd_q;
  wire last_bit = (bit_q == BYTE_BITS);

  // ----------------------------------------------------------------
  // sync and divider
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_sh_q <= 2'h3;
      div_q <= 16'h0000;
    end else begin
      sda_sh_q <= {sda_sh_q[0], bus.sda};
      div_q <= (tick || st_q == M_IDLE || st_q == M_NEXT) ? 16'h0000 : div_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= M_IDLE;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      step_q <= 4'h0;
      left_q <= 4'h0;
      rd_q <= 1'b0;
      rxm_q <= 1'b0;
      wd_q <= 8'h00;
      sh_q <= 8'h00;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      nack_q <= 1'b0;
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      rd_valid_q <= 1'b0;
      unique case (st_q)
        M_IDLE: begin
          if (cmd_go) begin
            st_q <= M_NEXT;
            busy_q <= 1'b1;
            nack_q <= 1'b0;
            step_q <= 4'h0;
            rd_q <= cmd_rd;
            wd_q <= cmd_wdata;
            left_q <= (cmd_nrd == 4'h0) ? 4'h1 : cmd_nrd;
          end
        end
        M_NEXT: begin
          ph_q <= 2'h0;
          bit_q <= 4'h0;
          rxm_q <= (cur == IT_RB);
          sh_q <= (cur == IT_RB) ? 8'hFF : tx_byte;
          st_q <= (cur == IT_S) ? M_START : (cur == IT_P) ? M_STOP : M_BIT;
        end
        M_START: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            // data falls while the clock is high
            if (ph_q == 2'h0) sda_oe_q <= 1'b0;
            if (ph_q == 2'h1) scl_oe_q <= 1'b0;
            if (ph_q == 2'h2) sda_oe_q <= 1'b1;
            if (ph_q == 2'h3) begin
              scl_oe_q <= 1'b1;
              step_q <= step_q + 4'h1;
              st_q <= M_NEXT;
            end
          end
        end
        M_BIT: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            if (ph_q == 2'h0) begin
              if (!last_bit) sda_oe_q <= ~rxm_q & ~sh_q[7];
              else sda_oe_q <= rxm_q & (left_q != 4'h1);
            end
            if (ph_q == 2'h1) scl_oe_q <= 1'b0;
            if (ph_q == 2'h2) begin
              if (!last_bit) sh_q <= {sh_q[6:0], sda_s};
              else if (!rxm_q && sda_s) nack_q <= 1'b1;
            end
            if (ph_q == 2'h3) begin
              scl_oe_q <= 1'b1;
              bit_q <= bit_q + 4'h1;
              if (last_bit) begin
                ph_q <= 2'h0;
                step_q <= step_q + 4'h1;
                st_q <= nack_q ? M_STOP : M_NEXT;
                if (rxm_q) begin
                  rd_data_q <= sh_q;
                  rd_valid_q <= 1'b1;
                  left_q <= left_q - 4'h1;
                end
              end
            end
          end
        end
        M_STOP: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            if (ph_q == 2'h0) sda_oe_q <= 1'b1;
            if (ph_q == 2'h1) scl_oe_q <= 1'b0;
            if (ph_q == 2'h2) sda_oe_q <= 1'b0;
            if (ph_q == 2'h3) begin
              st_q <= M_IDLE;
              busy_q <= 1'b0;
              done_q <= 1'b1;
            end
          end
        end
        default: begin
          st_q <= M_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bus.m_scl_o = 1'b0;
  assign bus.m_scl_oe = scl_oe_q;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_sda_oe = sda_oe_q;
  assign busy = busy_q;
  assign done = done_q;
  assign nack = nack_q;
  assign rd_data = rd_data_q;
  assign rd_valid = rd_valid_q;

endmodule // pwi_mst

// ---- pwi_chk.sv ----
/*
  checker for the wired two-wire bus between the master and slave ends.
  assumes QTR of at least 4, so every serial clock phase lasts 8+ clocks.
*/
`timescale 1ns/100ps
module pwi_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic m_scl_oe,
  input wire logic m_sda_oe,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda,
  input wire logic [6:0] wiper
);
  import pwi_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // slave drive
  // ----------------------------------------------------------------
  property p_slv_pull_clk_low;
    $rose(s_sda_oe) |-> !scl && !$past(scl);
  endproperty
  a_slv_pull_clk_low: assert property (p_slv_pull_clk_low)
    else $error("slave began pulling sda while scl high");

  property p_slv_free_clk_low;
    $fell(s_sda_oe) |-> !scl;
  endproperty
  a_slv_free_clk_low: assert property (p_slv_free_clk_low)
    else $error("slave released sda while scl high");

  property p_slv_holds_bit;
    $rose(s_sda_oe) |-> s_sda_oe [*8];
  endproperty
  a_slv_holds_bit: assert property (p_slv_holds_bit)
    else $error("slave low pulse shorter than a clock phase");

  // ----------------------------------------------------------------
  // wiper
  // ----------------------------------------------------------------
  // commit lands a few clocks after the fall, so scl must still be low
  property p_wiper_clk_low;
    $changed(wiper) |-> !scl && !$past(scl);
  endproperty
  a_wiper_clk_low: assert property (p_wiper_clk_low)
    else $error("wiper changed away from a falling clock");

  property p_wiper_preset;
    // the first sample may precede the reset taking hold, so wait one clock
    disable iff (1'b0) rst && $past(rst) |-> wiper == WIPER_RST;
  endproperty
  a_wiper_preset: assert property (p_wiper_preset)
    else $error("wiper not at mid-scale during reset");

  // ----------------------------------------------------------------
  // framing
  // ----------------------------------------------------------------
  property p_scl_high_len;
    $rose(scl) |-> scl [*8];
  endproperty
  a_scl_high_len: assert property (p_scl_high_len)
    else $error("scl high phase too short");

  property p_scl_low_len;
    $fell(scl) |-> !scl [*8];
  endproperty
  a_scl_low_len: assert property (p_scl_low_len)
    else $error("scl low phase too short");

  property p_idle_after_stop;
    $rose(sda) && scl && $past(scl) |-> (sda && scl) [*8];
  endproperty
  a_idle_after_stop: assert property (p_idle_after_stop)
    else $error("bus not idle after stop");

  // a receiver ack would be masked if the transmitter still pulled low
  property p_one_driver_at_rise;
    $rose(scl) && s_sda_oe |-> !m_sda_oe;
  endproperty
  a_one_driver_at_rise: assert property (p_one_driver_at_rise)
    else $error("both ends pulling sda at scl rise");

  c_slv_ack: cover property ($rose(s_sda_oe));
  c_stop: cover property ($rose(sda) && scl);
  c_wiper_new: cover property ($changed(wiper));
  c_restart: cover property ($fell(sda) && scl && !m_scl_oe);
endmodule // pwi_chk

// ---- pot_wiper_i2c_slave_tb.sv ----
/*
  self-checking bench: master and slave ends joined by pwi_if, plus a
  second pair whose master uses a foreign code.
  assumes QTR of 5 to keep every transfer short.
*/
`timescale 1ns/100ps
module pot_wiper_i2c_slave_tb;
  import pwi_pkg::*;

  logic clk, rst, cmd_go, go_b, cmd_rd, done, done_b, nack, nack_b, rd_valid, busy;
  logic [7:0] cmd_wdata, rd_data;
  logic [3:0] cmd_nrd;
  logic [6:0] wiper, wiper_b;
  int fails = 0, num_checks = 0, cyc = 0, starts = 0;
  logic [7:0] rq[$];
  logic bq[$];
  bit mon = 0;

  pwi_if bus();
  pwi_if bus_b();
  pwi_dev i_pwi_dev (.clk(clk), .rst(rst), .bus(bus), .wiper(wiper));
  pwi_mst #(.QTR(5)) i_pwi_mst (.clk(clk), .rst(rst), .bus(bus), .cmd_go(cmd_go),
    .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata), .cmd_nrd(cmd_nrd), .busy(busy), .done(done),
    .nack(nack), .rd_data(rd_data), .rd_valid(rd_valid));
  pwi_dev i_pwi_dev_b (.clk(clk), .rst(rst), .bus(bus_b), .wiper(wiper_b));
  // foreign code on purpose: the slave end must refuse it
  pwi_mst #(.QTR(5), .DEV_ID(7'h15)) i_pwi_mst_b (.clk(clk), .rst(rst), .bus(bus_b),
    .cmd_go(go_b), .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata), .cmd_nrd(cmd_nrd),
    .busy(), .done(done_b), .nack(nack_b), .rd_data(), .rd_valid());
  pwi_chk i_pwi_chk (.clk(clk), .rst(rst), .m_scl_oe(bus.m_scl_oe),
    .m_sda_oe(bus.m_sda_oe), .s_sda_oe(bus.s_sda_oe), .scl(bus.scl), .sda(bus.sda),
    .wiper(wiper));

  // ----------------------------------------------------------------
  // clock, monitors, timeout
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) if (rd_valid === 1'b1) rq.push_back(rd_data);
  always @(posedge bus.scl) if (mon) bq.push_back(bus.sda);
  always @(negedge bus.sda) if (mon && bus.scl === 1'b1) starts++;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one transfer; the wire monitor records every bit sampled on scl rise,
  // so a repeated start adds a 1 and the stop adds a 0
  task automatic run(input bit alt, input logic rd, input logic [7:0] wd,
                     input logic [3:0] n);
    int k;
    rq.delete();
    bq.delete();
    starts = 0;
    mon = 1;
    @(posedge clk);
    cmd_rd <= rd;
    cmd_wdata <= wd;
    cmd_nrd <= n;
    if (alt) go_b <= 1'b1;
    else cmd_go <= 1'b1;
    @(posedge clk);
    go_b <= 1'b0;
    cmd_go <= 1'b0;
    @(posedge clk);
    if (!alt) chk("busy", 8'h01, {7'h00, busy});
    k = 0;
    while ((alt ? done_b : done) !== 1'b1 && k < 5000) begin
      @(posedge clk);
      k++;
    end
    mon = 0;
    chk("done", 8'h01, {7'h00, k < 5000});
    if (!alt) chk("idle", 8'h00, {7'h00, busy});
  endtask

  // compare the recorded wire bits with the expected stream, first bit at top
  task automatic wire_chk(input logic [44:0] exp, input int nb);
    int i;
    chk("bit count", nb[7:0], 8'(bq.size()));
    for (i = 0; i < nb && i < bq.size(); i++)
      chk("wire bit", {7'h00, exp[nb-1-i]}, {7'h00, bq[i]});
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_preset_read();
    chk("preset", {1'b0, WIPER_RST}, {1'b0, wiper});
    run(0, RW_READ, 8'h00, 4'h1);
    chk("read byte", {1'b0, WIPER_RST}, rq.size() ? rq[0] : 8'hFF);
    wire_chk({DEV_ID_DFLT, RW_WRITE, 1'b0, WIPER_ADDR, 1'b0, 1'b1, DEV_ID_DFLT, RW_READ, 1'b0,
              1'b0, WIPER_RST, 1'b1, 1'b0}, 38);
    chk("starts", 8'h02, starts[7:0]);
    chk("nack", 8'h00, {7'h00, nack});
    $display("test preset_read done");
  endtask

  task automatic t_writes();
    logic [7:0] v[3] = '{8'h7F, 8'h00, 8'h2C};
    for (int j = 0; j < 3; j++) begin
      run(0, RW_WRITE, v[j], 4'h0);
      wire_chk({17'h0, DEV_ID_DFLT, RW_WRITE, 1'b0, WIPER_ADDR, 1'b0, v[j], 1'b0, 1'b0},
               28);
      chk("wiper", v[j], {1'b0, wiper});
      chk("nack", 8'h00, {7'h00, nack});
      chk("starts", 8'h01, starts[7:0]);
    end
    $display("test writes done");
  endtask

  task automatic t_read_burst();
    run(0, RW_READ, 8'h00, 4'h3);
    chk("byte count", 8'h03, 8'(rq.size()));
    foreach (rq[j]) chk("burst byte", 8'h2C, rq[j]);
    chk("nack", 8'h00, {7'h00, nack});
    chk("bit count", 8'h38, 8'(bq.size()));
    $display("test read_burst done");
  endtask

  task automatic t_foreign_id();
    run(1, RW_WRITE, 8'h11, 4'h0);
    chk("foreign nack", 8'h01, {7'h00, nack_b});
    chk("foreign wiper", {1'b0, WIPER_RST}, {1'b0, wiper_b});
    $display("test foreign_id done");
  endtask

  initial begin
    rst = 1'b1;
    cmd_go = 1'b0;
    go_b = 1'b0;
    cmd_rd = 1'b0;
    cmd_wdata = 8'h00;
    cmd_nrd = 4'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_preset_read();
    t_writes();
    t_read_burst();
    t_foreign_id();
    end_sim();
  end
endmodule // pot_wiper_i2c_slave_tb
